// ==== common/modbus_pkg.sv ====
// shared constants, crc helper and read-function check for the modbus rtu request link
package modbus_pkg;
	localparam logic [15:0] CRC_PRESET      = 16'hFFFF;
	localparam logic [15:0] CRC_POLY        = 16'hA001;
	localparam logic [15:0] CRC_RESIDUE     = 16'h0000;
	localparam logic [7:0]  FN_READ_HOLD    = 8'h03;
	localparam logic [7:0]  FN_READ_INPUT   = 8'h04;
	localparam logic [7:0]  FN_EXECUTE      = 8'h05;
	localparam logic [7:0]  EXC_FLAG        = 8'h80;
	localparam logic [7:0]  ERR_NONE        = 8'h00;
	localparam logic [7:0]  ERR_BAD_FUNC    = 8'h01;
	localparam logic [7:0]  ERR_BAD_ADDR    = 8'h02;
	localparam logic [7:0]  ERR_BAD_VALUE   = 8'h03;
	localparam logic [7:0]  BROADCAST_ADDR  = 8'h00;
	localparam logic [15:0] OP_NOP          = 16'h0000;
	localparam logic [15:0] OP_RESET        = 16'h0001;
	localparam logic [15:0] OP_CLEAR_EVENTS = 16'h0005;
	localparam logic [15:0] OP_CLEAR_OSC    = 16'h0006;
	localparam logic [15:0] OP_VIN_FIRST    = 16'h1000;
	localparam logic [15:0] OP_VIN_LAST     = 16'h101F;
	localparam logic [15:0] CODE_ON         = 16'hFF00;
	localparam logic [15:0] CODE_OFF        = 16'h0000;
	localparam logic [15:0] MAX_READ_REGS   = 16'h007D;
	localparam logic [15:0] REG_ONE         = 16'h0001;
	localparam logic [3:0]  REQ_BYTES       = 4'h8;
	localparam logic [3:0]  MIN_BYTES       = 4'h4;
	localparam logic [3:0]  CNT_SAT         = 4'h9;
	localparam logic [2:0]  IDX_ADDR        = 3'h0;
	localparam logic [2:0]  IDX_FN          = 3'h1;
	localparam logic [2:0]  IDX_A_HI        = 3'h2;
	localparam logic [2:0]  IDX_A_LO        = 3'h3;
	localparam logic [2:0]  IDX_B_HI        = 3'h4;
	localparam logic [2:0]  IDX_B_LO        = 3'h5;
	localparam logic [2:0]  IDX_CRC_HI      = 3'h7;
	localparam logic [1:0]  POS_FN          = 2'h1;
	localparam logic [1:0]  POS_THIRD       = 2'h2;
	localparam logic [1:0]  POS_DATA        = 2'h3;
	localparam int          CLK_PERIOD_NS   = 25;
	localparam int          RSP_TIMEOUT_US  = 1000;
	localparam int          RSP_TIMEOUT_CYCLES = (RSP_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// folds one byte into the working register, low bit first
	function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] a;
		logic        carry;
		a = {crc[15:8], crc[7:0] ^ data};
		for (int j = 0; j < 8; j++) begin
			carry = a[0];
			a = {1'b0, a[15:1]};
			if (carry) begin
				a = a ^ CRC_POLY;
			end
		end
		return a;
	endfunction

	function automatic logic is_read_fn(input logic [7:0] fn);
		return fn == FN_READ_HOLD || fn == FN_READ_INPUT;
	endfunction
endpackage

// ==== common/modbus_link_if.sv ====
// byte stream link between the modbus master end and the slave end
`timescale 1ns/10ps
interface modbus_link_if;
	logic [7:0] m2s_data;
	logic       m2s_valid;
	logic       m2s_end;
	logic [7:0] s2m_data;
	logic       s2m_valid;
	logic       s2m_end;

	modport slave_end (
		input  m2s_data,
		input  m2s_valid,
		input  m2s_end,
		output s2m_data,
		output s2m_valid,
		output s2m_end
	);
	modport master_end (
		output m2s_data,
		output m2s_valid,
		output m2s_end,
		input  s2m_data,
		input  s2m_valid,
		input  s2m_end
	);
endinterface

// ==== hw/modbus_master_end.sv ====
// modbus master end: builds requests, checks and unpacks replies
`timescale 1ns/10ps
module modbus_master_end #(
	parameter int TIMEOUT_CYCLES = modbus_pkg::RSP_TIMEOUT_CYCLES
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	modbus_link_if.master_end     link,
	input  wire logic             req_valid,
	input  wire logic [7:0]       req_slave,
	input  wire logic [7:0]       req_fn,
	input  wire logic [15:0]      req_word_a,
	input  wire logic [15:0]      req_word_b,
	output logic                  req_ready_q,
	output logic                  req_refused_q,
	output logic [15:0]           rsp_word_q,
	output logic                  rsp_word_valid_q,
	output logic                  rsp_done_q,
	output logic                  rsp_crc_ok_q,
	output logic                  rsp_exc_q,
	output logic [7:0]            rsp_err_q,
	output logic                  rsp_timeout_q
);
	localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
	localparam logic [TW-1:0] TIMER_LAST = TW'(TIMEOUT_CYCLES - 1);

	if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 16777216) begin : g_check
		$error("TIMEOUT_CYCLES out of range");
	end

	typedef enum logic [2:0] {M_IDLE, M_SEND, M_CRC_LO, M_CRC_HI, M_END, M_WAIT} master_state_type;

	master_state_type state_q, state_d;
	logic [7:0]  slave_q, fn_q, rsp_fn_q, third_q, hi_q, m2s_data_q;
	logic [15:0] a_q, b_q, words_left_q, tx_crc_q, rx_crc_q;
	logic [2:0]  idx_q;
	logic [1:0]  pos_q;
	logic        have_hi_q, m2s_valid_q, m2s_end_q;
	logic [TW-1:0] timer_q;

	assign link.m2s_data  = m2s_data_q;
	assign link.m2s_valid = m2s_valid_q;
	assign link.m2s_end   = m2s_end_q;

	wire        idle    = state_q == M_IDLE;
	wire        refuse  = req_valid && idle && modbus_pkg::is_read_fn(req_fn)
	                      && (req_word_b == 16'h0000 || req_word_b > modbus_pkg::MAX_READ_REGS);
	wire        start   = req_valid && idle && !refuse;
	wire        timeout = state_q == M_WAIT && timer_q == TIMER_LAST;
	wire        rx_byte = state_q == M_WAIT && link.s2m_valid;
	wire        rx_done = state_q == M_WAIT && link.s2m_end;
	// the reply words are paired only when the function byte shows a normal read reply
	wire        pairing = rx_byte && pos_q == modbus_pkg::POS_DATA && |words_left_q
	                      && modbus_pkg::is_read_fn(rsp_fn_q);
	wire [7:0]  req_byte = idx_q == modbus_pkg::IDX_ADDR ? slave_q :
	                       idx_q == modbus_pkg::IDX_FN   ? fn_q :
	                       idx_q == modbus_pkg::IDX_A_HI ? a_q[15:8] :
	                       idx_q == modbus_pkg::IDX_A_LO ? a_q[7:0] :
	                       idx_q == modbus_pkg::IDX_B_HI ? b_q[15:8] : b_q[7:0];
	wire [7:0]  tx_byte  = state_q == M_CRC_LO ? tx_crc_q[7:0] :
	                       state_q == M_CRC_HI ? tx_crc_q[15:8] : req_byte;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			M_IDLE:   if (start) state_d = M_SEND;
			M_SEND:   if (idx_q == modbus_pkg::IDX_B_LO) state_d = M_CRC_LO;
			M_CRC_LO: state_d = M_CRC_HI;
			M_CRC_HI: state_d = M_END;
			M_END:    state_d = slave_q == modbus_pkg::BROADCAST_ADDR ? M_IDLE : M_WAIT;
			M_WAIT:   if (rx_done || timeout) state_d = M_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q     <= M_IDLE;
			req_ready_q <= 1'b0;
			idx_q       <= '0;
			m2s_data_q  <= '0;
			m2s_valid_q <= 1'b0;
			m2s_end_q   <= 1'b0;
			tx_crc_q    <= modbus_pkg::CRC_PRESET;
		end else begin
			state_q     <= state_d;
			req_ready_q <= state_d == M_IDLE;
			idx_q       <= state_q == M_SEND ? idx_q + 3'h1 : '0;
			m2s_data_q  <= tx_byte;
			m2s_valid_q <= state_q == M_SEND || state_q == M_CRC_LO || state_q == M_CRC_HI;
			m2s_end_q   <= state_q == M_END;
			if (state_q == M_SEND) begin
				tx_crc_q <= modbus_pkg::crc_byte(tx_crc_q, req_byte);
			end else if (idle) begin
				tx_crc_q <= modbus_pkg::CRC_PRESET;
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			slave_q <= '0;
			fn_q    <= '0;
			a_q     <= '0;
			b_q     <= '0;
		end else if (start) begin
			slave_q <= req_slave;
			fn_q    <= req_fn;
			a_q     <= req_word_a;
			b_q     <= req_word_b;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pos_q        <= '0;
			rx_crc_q     <= modbus_pkg::CRC_PRESET;
			rsp_fn_q     <= '0;
			third_q      <= '0;
			timer_q      <= '0;
			words_left_q <= '0;
			have_hi_q    <= 1'b0;
			hi_q         <= '0;
		end else if (state_q != M_WAIT) begin
			pos_q        <= '0;
			rx_crc_q     <= modbus_pkg::CRC_PRESET;
			timer_q      <= '0;
			words_left_q <= b_q;
			have_hi_q    <= 1'b0;
		end else begin
			timer_q <= rx_byte ? '0 : timer_q + TW'(1);
			if (rx_byte) begin
				rx_crc_q <= modbus_pkg::crc_byte(rx_crc_q, link.s2m_data);
				if (pos_q != modbus_pkg::POS_DATA) pos_q <= pos_q + 2'h1;
				if (pos_q == modbus_pkg::POS_FN) rsp_fn_q <= link.s2m_data;
				if (pos_q == modbus_pkg::POS_THIRD) third_q <= link.s2m_data;
			end
			if (pairing) begin
				have_hi_q <= !have_hi_q;
				hi_q      <= link.s2m_data;
				if (have_hi_q) words_left_q <= words_left_q - modbus_pkg::REG_ONE;
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			req_refused_q    <= 1'b0;
			rsp_word_q       <= '0;
			rsp_word_valid_q <= 1'b0;
			rsp_done_q       <= 1'b0;
			rsp_crc_ok_q     <= 1'b0;
			rsp_exc_q        <= 1'b0;
			rsp_err_q        <= modbus_pkg::ERR_NONE;
			rsp_timeout_q    <= 1'b0;
		end else begin
			req_refused_q    <= refuse;
			rsp_word_valid_q <= pairing && have_hi_q;
			if (pairing && have_hi_q) rsp_word_q <= {hi_q, link.s2m_data};
			rsp_done_q       <= rx_done;
			rsp_timeout_q    <= timeout;
			if (rx_done) begin
				rsp_crc_ok_q <= rx_crc_q == modbus_pkg::CRC_RESIDUE;
				rsp_exc_q    <= rsp_fn_q[7];
				rsp_err_q    <= rsp_fn_q[7] ? third_q : modbus_pkg::ERR_NONE;
			end
		end
	end
endmodule

// ==== hw/modbus_slave_end.sv ====
// modbus slave end: checks requests, reads registers, executes operations, replies
`timescale 1ns/10ps
// Operation
// - crc working register starts at all ones
// - xor byte into low half, eight shifts
// - shift right, zero in, lsb is carry
// - final register after all bytes is crc
// - only functions 03, 04, 05, 06, 10; code takes only 03, 04, 05 and answers 06 and 10 with error 01
// - functions 03 and 04 read identically
// - registers are 16 bits, high byte first
// - master asks at most 125 registers
// - read request: addr, fn, start, count, crc
// - read reply: addr, fn, 2*count, data, crc
// - execute request: opcode, then FF 00; code also takes 00 00 for virtual-input opcodes and clears that input
// - opcode 0000 acknowledged, does nothing
// - opcode 0001 acts as reset key
// - 0005 clears events, 0006 clears oscillography
// - opcodes 1000-101F set 32 virtual inputs
// - exception: function with msb set, error code
// - bad crc packet silently discarded
// - address zero acted on only for 05
module modbus_slave_end #(
	parameter int NUM_VIN = 32
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	modbus_link_if.slave_end      link,
	input  wire logic [7:0]       slave_addr,
	output logic                  reg_rd_en_q,
	output logic [15:0]           reg_rd_addr_q,
	input  wire logic [15:0]      reg_rd_data,
	output logic                  reset_cmd_q,
	output logic                  clear_events_q,
	output logic                  clear_osc_q,
	output logic [NUM_VIN-1:0]    virtual_in_q
);
	localparam int VIN_W = $clog2(NUM_VIN);
	localparam logic [15:0] VIN_LIMIT = 16'(NUM_VIN);

	if (NUM_VIN < 2 || NUM_VIN > 32) begin : g_check
		$error("NUM_VIN must lie between 2 and 32");
	end

	typedef enum logic [3:0] {
		S_RX, S_HEAD, S_RD_REQ, S_RD_HI, S_RD_LO, S_CRC_LO, S_CRC_HI, S_ECHO, S_END
	} slave_state_type;

	slave_state_type state_q, state_d;
	logic [7:0]  pkt_q [8];
	logic [3:0]  rx_cnt_q;
	logic [15:0] rx_crc_q, tx_crc_q, left_q;
	logic [2:0]  idx_q;
	logic [7:0]  lo_q, err_q, s2m_data_q;
	logic        s2m_valid_q, s2m_end_q;
	logic        emit, fold;
	logic [7:0]  tx_byte;

	assign link.s2m_data  = s2m_data_q;
	assign link.s2m_valid = s2m_valid_q;
	assign link.s2m_end   = s2m_end_q;

	// request fields, valid while the packet buffer is held through the reply
	wire [7:0]  fn       = pkt_q[modbus_pkg::IDX_FN];
	wire [15:0] word_a   = {pkt_q[modbus_pkg::IDX_A_HI], pkt_q[modbus_pkg::IDX_A_LO]};
	wire [15:0] word_b   = {pkt_q[modbus_pkg::IDX_B_HI], pkt_q[modbus_pkg::IDX_B_LO]};
	wire [15:0] vin_off  = word_a - modbus_pkg::OP_VIN_FIRST;
	wire        is_read  = modbus_pkg::is_read_fn(fn);
	wire        is_exec  = fn == modbus_pkg::FN_EXECUTE;
	wire        len_ok   = rx_cnt_q == modbus_pkg::REQ_BYTES;
	wire        cnt_ok   = |word_b && word_b <= modbus_pkg::MAX_READ_REGS;
	wire        vin_hit  = word_a >= modbus_pkg::OP_VIN_FIRST && vin_off < VIN_LIMIT;
	wire        op_ok    = word_a == modbus_pkg::OP_NOP || word_a == modbus_pkg::OP_RESET
	                       || word_a == modbus_pkg::OP_CLEAR_EVENTS || word_a == modbus_pkg::OP_CLEAR_OSC
	                       || vin_hit;
	wire        val_ok   = word_b == modbus_pkg::CODE_ON || (vin_hit && word_b == modbus_pkg::CODE_OFF);
	wire [7:0]  err      = !is_read && !is_exec ? modbus_pkg::ERR_BAD_FUNC :
	                       !len_ok              ? modbus_pkg::ERR_BAD_VALUE :
	                       is_read && !cnt_ok   ? modbus_pkg::ERR_BAD_VALUE :
	                       is_exec && !op_ok    ? modbus_pkg::ERR_BAD_ADDR :
	                       is_exec && !val_ok   ? modbus_pkg::ERR_BAD_VALUE : modbus_pkg::ERR_NONE;
	// a zero residue over data plus the appended crc means the packet arrived intact
	wire        crc_ok   = rx_cnt_q >= modbus_pkg::MIN_BYTES && rx_crc_q == modbus_pkg::CRC_RESIDUE;
	wire        bcast    = pkt_q[modbus_pkg::IDX_ADDR] == modbus_pkg::BROADCAST_ADDR;
	wire        addr_me  = pkt_q[modbus_pkg::IDX_ADDR] == slave_addr;
	wire        accept   = state_q == S_RX && link.m2s_end && crc_ok
	                       && (addr_me || (bcast && is_exec));
	wire        reply    = accept && !bcast;
	wire        act      = accept && is_exec && err == modbus_pkg::ERR_NONE;
	wire        exc_flag = err_q != modbus_pkg::ERR_NONE;
	wire [7:0]  count_b  = {word_b[6:0], 1'b0};
	wire [7:0]  head_b   = idx_q == modbus_pkg::IDX_ADDR ? pkt_q[modbus_pkg::IDX_ADDR] :
	                       idx_q == modbus_pkg::IDX_FN   ? (exc_flag ? fn | modbus_pkg::EXC_FLAG : fn) :
	                       exc_flag ? err_q : count_b;

	always_comb begin
		state_d = state_q;
		emit    = 1'b0;
		fold    = 1'b0;
		tx_byte = head_b;
		unique case (state_q)
			S_RX: begin
				if (reply) state_d = (err != modbus_pkg::ERR_NONE || is_read) ? S_HEAD : S_ECHO;
			end
			S_HEAD: begin
				emit = 1'b1;
				fold = 1'b1;
				if (idx_q == modbus_pkg::IDX_A_HI) state_d = exc_flag ? S_CRC_LO : S_RD_REQ;
			end
			S_RD_REQ: state_d = S_RD_HI;
			S_RD_HI: begin
				emit    = 1'b1;
				fold    = 1'b1;
				tx_byte = reg_rd_data[15:8];
				state_d = S_RD_LO;
			end
			S_RD_LO: begin
				emit    = 1'b1;
				fold    = 1'b1;
				tx_byte = lo_q;
				state_d = left_q == modbus_pkg::REG_ONE ? S_CRC_LO : S_RD_REQ;
			end
			S_CRC_LO: begin
				emit    = 1'b1;
				tx_byte = tx_crc_q[7:0];
				state_d = S_CRC_HI;
			end
			S_CRC_HI: begin
				emit    = 1'b1;
				tx_byte = tx_crc_q[15:8];
				state_d = S_END;
			end
			S_ECHO: begin
				emit    = 1'b1;
				tx_byte = pkt_q[idx_q];
				if (idx_q == modbus_pkg::IDX_CRC_HI) state_d = S_END;
			end
			S_END: state_d = S_RX;
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q     <= S_RX;
			idx_q       <= '0;
			s2m_data_q  <= '0;
			s2m_valid_q <= 1'b0;
			s2m_end_q   <= 1'b0;
			tx_crc_q    <= modbus_pkg::CRC_PRESET;
		end else begin
			state_q     <= state_d;
			idx_q       <= (state_q == S_HEAD || state_q == S_ECHO) && state_d == state_q ? idx_q + 3'h1 : '0;
			s2m_data_q  <= tx_byte;
			s2m_valid_q <= emit;
			s2m_end_q   <= state_q == S_END;
			if (fold) begin
				tx_crc_q <= modbus_pkg::crc_byte(tx_crc_q, tx_byte);
			end else if (state_q == S_RX) begin
				tx_crc_q <= modbus_pkg::CRC_PRESET;
			end
		end
	end

	// bytes arriving while a reply is under way are dropped; the master waits for the reply
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rx_cnt_q <= '0;
			rx_crc_q <= modbus_pkg::CRC_PRESET;
			for (int i = 0; i < 8; i++) pkt_q[i] <= '0;
		end else if (state_q == S_RX) begin
			if (link.m2s_end) begin
				rx_cnt_q <= '0;
				rx_crc_q <= modbus_pkg::CRC_PRESET;
			end else if (link.m2s_valid) begin
				if (rx_cnt_q < modbus_pkg::REQ_BYTES) pkt_q[rx_cnt_q[2:0]] <= link.m2s_data;
				if (rx_cnt_q != modbus_pkg::CNT_SAT) rx_cnt_q <= rx_cnt_q + 4'h1;
				rx_crc_q <= modbus_pkg::crc_byte(rx_crc_q, link.m2s_data);
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			err_q         <= modbus_pkg::ERR_NONE;
			left_q        <= '0;
			reg_rd_addr_q <= '0;
			reg_rd_en_q   <= 1'b0;
			lo_q          <= '0;
		end else begin
			reg_rd_en_q <= state_q == S_RD_REQ;
			if (reply) begin
				err_q         <= err;
				left_q        <= word_b;
				reg_rd_addr_q <= word_a;
			end
			if (state_q == S_RD_HI) lo_q <= reg_rd_data[7:0];
			if (state_q == S_RD_LO) begin
				left_q        <= left_q - modbus_pkg::REG_ONE;
				reg_rd_addr_q <= reg_rd_addr_q + modbus_pkg::REG_ONE;
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			reset_cmd_q    <= 1'b0;
			clear_events_q <= 1'b0;
			clear_osc_q    <= 1'b0;
			virtual_in_q   <= '0;
		end else begin
			reset_cmd_q    <= act && word_a == modbus_pkg::OP_RESET;
			clear_events_q <= act && word_a == modbus_pkg::OP_CLEAR_EVENTS;
			clear_osc_q    <= act && word_a == modbus_pkg::OP_CLEAR_OSC;
			if (act && vin_hit) virtual_in_q[vin_off[VIN_W-1:0]] <= word_b == modbus_pkg::CODE_ON;
		end
	end
endmodule

// ==== tb/modbus_link_checker.sv ====
// checker for request and reply framing on the link
`timescale 1ns/10ps
module modbus_link_checker (
	input wire logic       core_clk,
	input wire logic       reset,
	input wire logic [7:0] m2s_data,
	input wire logic       m2s_valid,
	input wire logic       m2s_end,
	input wire logic [7:0] s2m_data,
	input wire logic       s2m_valid,
	input wire logic       s2m_end
);
	logic [7:0] req_q [8];
	logic [2:0] m_idx_q;
	logic [8:0] s_idx_q;
	logic [7:0] s_fn_q;
	wire        is_echo = s_fn_q == modbus_pkg::FN_EXECUTE;
	wire        is_read = s_fn_q == 8'h03 || s_fn_q == 8'h04;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	always_ff @(posedge core_clk) if (m2s_valid) req_q[m_idx_q] <= m2s_data;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			m_idx_q <= 3'h0;
			s_idx_q <= 9'h000;
			s_fn_q <= 8'h00;
		end else begin
			m_idx_q <= m2s_end ? 3'h0 : m_idx_q + 3'(m2s_valid);
			s_idx_q <= s2m_end ? 9'h000 : s_idx_q + 9'(s2m_valid);
			if (s2m_valid && s_idx_q == 9'h001) s_fn_q <= s2m_data;
		end
	end
	sequence reply_start;
		s2m_valid && s_idx_q == 9'h000;
	endsequence
	sequence exc_head;
		reply_start ##1 (s2m_valid && s2m_data[7]);
	endsequence
	sequence echo_head;
		reply_start ##1 (s2m_valid && s2m_data == modbus_pkg::FN_EXECUTE);
	endsequence
	a_req_frame: assert property ($rose(m2s_valid) |-> m2s_valid [*8] ##1 (m2s_end && !m2s_valid))
		else $error("request frame malformed");
	a_reply_delay: assert property (reply_start |-> $past(m2s_end, 2))
		else $error("reply start late or early");
	a_addr_echo: assert property (reply_start |-> s2m_data == req_q[0])
		else $error("reply address wrong");
	a_fn_echo: assert property (s2m_valid && s_idx_q == 9'h001 |-> s2m_data[6:0] == req_q[1][6:0])
		else $error("reply function wrong");
	a_exc_frame: assert property (exc_head |=> s2m_valid [*3] ##1 s2m_end)
		else $error("exception frame malformed");
	a_echo_frame: assert property (echo_head |=> s2m_valid [*6] ##1 s2m_end)
		else $error("echo frame malformed");
	a_echo_body: assert property (s2m_valid && is_echo && s_idx_q > 9'h001 |-> s2m_data == req_q[s_idx_q[2:0]])
		else $error("echo byte differs");
	a_byte_count: assert property (s2m_valid && is_read && s_idx_q == 9'h002 |-> s2m_data == {req_q[5][6:0], 1'b0})
		else $error("byte count wrong");
	a_bcast_quiet: assert property (m2s_end && req_q[0] == modbus_pkg::BROADCAST_ADDR |=> !s2m_valid [*4])
		else $error("reply to broadcast");
	a_end_pulse: assert property (s2m_end |-> !s2m_valid && $past(s2m_valid))
		else $error("reply end misplaced");
endmodule

// ==== tb/tb_modbus_slave_request_handler.sv ====
// bench: master and slave ends on one link, a second slave fed by hand
`timescale 1ns/10ps
module tb_modbus_slave_request_handler;
	typedef logic [7:0] byte_q_type [$];
	typedef struct packed {
		logic [7:0]  fn;
		logic [15:0] a;
		logic [15:0] b;
		logic [7:0]  err;
	} exc_case_type;
	logic         core_clk = 1'b0;
	logic         reset = 1'b1;
	logic         req_valid = 1'b0;
	logic [7:0]   req_slave = 8'h00, req_fn = 8'h00, rsp_err_q;
	logic [15:0]  req_word_a = 16'h0000, req_word_b = 16'h0000, rsp_word_q, rd_addr, rd_addr2, w;
	logic         req_ready_q, req_refused_q, rsp_word_valid_q, rsp_done_q, rsp_crc_ok_q, rsp_exc_q, rsp_timeout_q;
	logic         rst_pulse, ev_pulse, osc_pulse, rst_pulse2, got_ref, got_done, got_to, rd_en;
	logic [31:0]  vin, exp_vin = 32'h0000_0000;
	logic [15:0]  words [$];
	logic [15:0]  ops [4] = '{16'h0000, 16'h0001, 16'h0005, 16'h0006};
	byte_q_type   rx, tx, rx2, req_bytes, exp;
	int           fail_count = 0, n_checks = 0, cnt_rst = 0, cnt_ev = 0, cnt_osc = 0, cnt_rst2 = 0, cnt_rd = 0;
	exc_case_type exc_cases [5] = '{'{8'h05, 16'h0002, 16'hFF00, 8'h02}, '{8'h05, 16'h1020, 16'hFF00, 8'h02},
		'{8'h05, 16'h0001, 16'h1234, 8'h03}, '{8'h06, 16'h4051, 16'h00C8, 8'h01}, '{8'h10, 16'h4051, 16'h0002, 8'h01}};

	modbus_link_if link ();
	modbus_link_if link2 ();
	modbus_master_end #(.TIMEOUT_CYCLES(200)) modbus_master_end_i (.core_clk(core_clk), .reset(reset), .link(link),
		.req_valid(req_valid), .req_slave(req_slave), .req_fn(req_fn), .req_word_a(req_word_a),
		.req_word_b(req_word_b), .req_ready_q(req_ready_q), .req_refused_q(req_refused_q), .rsp_word_q(rsp_word_q),
		.rsp_word_valid_q(rsp_word_valid_q), .rsp_done_q(rsp_done_q), .rsp_crc_ok_q(rsp_crc_ok_q),
		.rsp_exc_q(rsp_exc_q), .rsp_err_q(rsp_err_q), .rsp_timeout_q(rsp_timeout_q));
	modbus_slave_end #(.NUM_VIN(32)) modbus_slave_end_i (.core_clk(core_clk), .reset(reset), .link(link),
		.slave_addr(8'h11), .reg_rd_en_q(rd_en), .reg_rd_addr_q(rd_addr), .reg_rd_data(rd_addr ^ 16'hA5C3),
		.reset_cmd_q(rst_pulse), .clear_events_q(ev_pulse), .clear_osc_q(osc_pulse), .virtual_in_q(vin));
	// second slave lets the bench break the master's side of the contract
	modbus_slave_end #(.NUM_VIN(32)) modbus_slave_end_fault_i (.core_clk(core_clk), .reset(reset), .link(link2),
		.slave_addr(8'h11), .reg_rd_en_q(), .reg_rd_addr_q(rd_addr2), .reg_rd_data(rd_addr2 ^ 16'hA5C3),
		.reset_cmd_q(rst_pulse2), .clear_events_q(), .clear_osc_q(), .virtual_in_q());
	modbus_link_checker modbus_link_checker_i (.core_clk(core_clk), .reset(reset), .m2s_data(link.m2s_data),
		.m2s_valid(link.m2s_valid), .m2s_end(link.m2s_end), .s2m_data(link.s2m_data),
		.s2m_valid(link.s2m_valid), .s2m_end(link.s2m_end));

	initial forever #12.5 core_clk = ~core_clk;

	always @(negedge core_clk) begin
		if (link.s2m_valid === 1'b1) rx.push_back(link.s2m_data);
		if (link.m2s_valid === 1'b1) tx.push_back(link.m2s_data);
		if (link2.s2m_valid === 1'b1) rx2.push_back(link2.s2m_data);
		if (rsp_word_valid_q === 1'b1) words.push_back(rsp_word_q);
		if (req_refused_q === 1'b1) got_ref = 1'b1;
		if (rsp_done_q === 1'b1) got_done = 1'b1;
		if (rsp_timeout_q === 1'b1) got_to = 1'b1;
		cnt_rd += int'(rd_en === 1'b1);
		cnt_rst += int'(rst_pulse === 1'b1);
		cnt_ev += int'(ev_pulse === 1'b1);
		cnt_osc += int'(osc_pulse === 1'b1);
		cnt_rst2 += int'(rst_pulse2 === 1'b1);
	end

	function automatic void add_crc(ref byte_q_type q);
		logic [15:0] a;
		a = 16'hFFFF;
		foreach (q[i]) begin
			a[7:0] = a[7:0] ^ q[i];
			repeat (8) a = a[0] ? ((a >> 1) ^ 16'hA001) : (a >> 1);
		end
		q.push_back(a[7:0]);
		q.push_back(a[15:8]);
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
		n_checks++;
		if (seen !== expv) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, expv, seen);
		end
	endtask

	task automatic check_q(input string name, input byte_q_type seen, input byte_q_type expq);
		check(name, seen.size(), expq.size());
		foreach (expq[i]) check(name, seen[i], expq[i]);
	endtask

	// one request through the master end; returns once the master is idle again
	task automatic do_req(input logic [7:0] sl, input logic [7:0] fn, input logic [15:0] a, input logic [15:0] b);
		int n;
		n = 0;
		rx.delete();
		tx.delete();
		words.delete();
		got_ref = 1'b0;
		got_done = 1'b0;
		got_to = 1'b0;
		req_bytes = '{sl, fn, a[15:8], a[7:0], b[15:8], b[7:0]};
		add_crc(req_bytes);
		while (req_ready_q !== 1'b1) @(negedge core_clk);
		@(posedge core_clk);
		req_valid <= 1'b1;
		req_slave <= sl;
		req_fn <= fn;
		req_word_a <= a;
		req_word_b <= b;
		@(posedge core_clk);
		req_valid <= 1'b0;
		do begin
			@(negedge core_clk);
			n++;
		end while ((n < 3 || req_ready_q !== 1'b1) && n < 3000);
		repeat (3) @(negedge core_clk);
		if (!got_ref) check_q("request bytes", tx, req_bytes);
	endtask

	// hand-made frame on the second link; the data line toggles once released
	task automatic send2(input byte_q_type q);
		rx2.delete();
		foreach (q[i]) begin
			@(posedge core_clk);
			link2.m2s_valid <= 1'b1;
			link2.m2s_data <= q[i];
		end
		@(posedge core_clk);
		link2.m2s_valid <= 1'b0;
		link2.m2s_data <= ~q[q.size() - 1];
		link2.m2s_end <= 1'b1;
		@(posedge core_clk);
		link2.m2s_end <= 1'b0;
		repeat (20) @(negedge core_clk);
	endtask

	task automatic summarize();
		if (fail_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		summarize();
	end

	initial begin
		link2.m2s_valid = 1'b0;
		link2.m2s_end = 1'b0;
		link2.m2s_data = 8'h00;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		for (int f = 3; f < 5; f++) begin
			do_req(8'h11, 8'(f), 16'h4050, 16'h0003);
			exp = '{8'h11, 8'(f), 8'h06};
			for (int k = 0; k < 3; k++) begin
				w = (16'h4050 + 16'(k)) ^ 16'hA5C3;
				exp.push_back(w[15:8]);
				exp.push_back(w[7:0]);
				check("read word", words[k], w);
			end
			add_crc(exp);
			check_q("read reply", rx, exp);
			check("reply crc", rsp_crc_ok_q, 1'b1);
			check("reply done", got_done, 1'b1);
			check("read not exception", rsp_exc_q, 1'b0);
		end
		do_req(8'h11, 8'h03, 16'h0000, 16'h007D);
		check("max words", words.size(), 125);
		check("last word", words[124], 16'h007C ^ 16'hA5C3);
		check("max reply size", rx.size(), 255);
		check("register reads", cnt_rd, 32'h0000_0083);
		for (int c = 0; c < 2; c++) begin
			do_req(8'h11, 8'h04, 16'h4050, c ? 16'h007E : 16'h0000);
			check("count refused", got_ref, 1'b1);
			check("nothing sent", tx.size(), 0);
		end
		foreach (ops[i]) begin
			do_req(8'h11, 8'h05, ops[i], 16'hFF00);
			check_q("echo reply", rx, req_bytes);
		end
		check("reset pulses", cnt_rst, 1);
		check("event clears", cnt_ev, 1);
		check("osc clears", cnt_osc, 1);
		for (int k = 0; k < 32; k++) begin
			do_req(8'h11, 8'h05, 16'h1000 + 16'(k), 16'hFF00);
			exp_vin[k] = 1'b1;
			check("virtual inputs", vin, exp_vin);
		end
		do_req(8'h11, 8'h05, 16'h101F, 16'h0000);
		check("virtual off", vin, 32'h7FFF_FFFF);
		foreach (exc_cases[i]) begin
			do_req(8'h11, exc_cases[i].fn, exc_cases[i].a, exc_cases[i].b);
			exp = '{8'h11, exc_cases[i].fn | 8'h80, exc_cases[i].err};
			add_crc(exp);
			check_q("exception reply", rx, exp);
			check("error code", rsp_err_q, exc_cases[i].err);
			check("exception flag", rsp_exc_q, 1'b1);
		end
		check("no action on error", cnt_rst, 1);
		do_req(8'h00, 8'h05, 16'h0001, 16'hFF00);
		check("broadcast silent", rx.size(), 0);
		check("broadcast acted", cnt_rst, 2);
		do_req(8'h00, 8'h04, 16'h4050, 16'h0001);
		check("broadcast read silent", rx.size(), 0);
		do_req(8'h22, 8'h03, 16'h4050, 16'h0001);
		check("foreign silent", rx.size(), 0);
		check("reply timeout", got_to, 1'b1);
		check("no reply end", got_done, 1'b0);
		exp = '{8'h11, 8'h05, 8'h00, 8'h01, 8'hFF, 8'h00};
		add_crc(exp);
		exp[6] = exp[6] ^ 8'h01;
		send2(exp);
		check("bad crc silent", rx2.size(), 0);
		exp[6] = exp[6] ^ 8'h01;
		send2(exp);
		check_q("fault link echo", rx2, exp);
		check("one action", cnt_rst2, 1);
		for (int c = 0; c < 2; c++) begin
			exp = '{8'h11, 8'h03, 8'h00, 8'h00, 8'h00, c ? 8'h7E : 8'h00};
			add_crc(exp);
			send2(exp);
			exp = '{8'h11, 8'h83, 8'h03};
			add_crc(exp);
			check_q("bad count reply", rx2, exp);
		end
		summarize();
	end
endmodule
